// ---- cdsv_regs.svh ----
`ifndef CDSV_REGS_SVH
`define CDSV_REGS_SVH

// I/O port addresses
`define CDSV_INDEX_PORT 16'h002E
`define CDSV_DATA_PORT 16'h002F

// Unlock and lock bytes for the index port
`define CDSV_UNLOCK_BYTE 8'h87
`define CDSV_LOCK_BYTE 8'hAA

// Register indexes
`define CDSV_IDX_LDN_SELECT 8'h07
`define CDSV_IDX_ACTIVATE 8'h30
`define CDSV_IDX_CONTROL 8'hF0
`define CDSV_IDX_TIME_BASE 8'hF5
`define CDSV_IDX_TIMEOUT 8'hF6

// Logical device number of the countdown supervisor
`define CDSV_SUPERVISOR_LDN 8'h07

// Field positions
`define CDSV_ACTIVATE_BIT 0
`define CDSV_CONTROL_ARM_BIT 7

// Time base codes
`define CDSV_BASE_SECONDS 8'h71
`define CDSV_BASE_MINUTES 8'h79

// Reset values
`define CDSV_RST_BYTE 8'h00
`define CDSV_RST_TIME_BASE 8'h71
`define CDSV_RST_IDLE_READ 8'hFF

// Timing
`define CDSV_CLK_PERIOD_NS 32'h00000019
`define CDSV_SECOND_NS 32'h3B9ACA00
`define CDSV_SEC_CYCLES (`CDSV_SECOND_NS / `CDSV_CLK_PERIOD_NS)
`define CDSV_MIN_SECONDS 8'h3C
`define CDSV_RST_HOLD_CYCLES 8'h10

`endif

// ---- cdsv_pkg.sv ----
package cdsv_pkg;

  // Unlock sequence states, one-hot
  typedef enum logic [2:0] {
    CDSV_LOCKED = 3'b001,
    CDSV_HALF = 3'b010,
    CDSV_OPEN = 3'b100
  } cdsv_lock_type;

  // Byte carried on the I/O port
  typedef logic [7:0] cdsv_byte_type;

endpackage : cdsv_pkg

// ---- cdsv_tick_if.sv ----
`timescale 1ns/1ps
// Link between the supervisor core and its time-base prescaler
interface cdsv_tick_if;
  logic ce; // Clock enable
  logic restart; // Restart the current unit
  logic minute_mode; // Unit is one minute
  logic unit_tick; // One unit elapsed
  modport core (output ce, output restart, output minute_mode, input unit_tick);
  modport pre (input ce, input restart, input minute_mode, output unit_tick);
endinterface : cdsv_tick_if

// ---- cdsv_prescaler.sv ----
`timescale 1ns/1ps
`include "cdsv_regs.svh"
// Divides the core clock down to one-second or one-minute ticks
module cdsv_prescaler
  import cdsv_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `CDSV_SEC_CYCLES
) (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset
  cdsv_tick_if.pre tk // Tick link
);

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1); // Last cycle of a second

  logic [31:0] cyc_reg; // Cycles within the second
  logic [7:0] sec_reg; // Seconds within the minute
  logic sec_end; // Last cycle of a second

  assign sec_end = (cyc_reg == SEC_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Cycle counter; restart forces a whole fresh unit
  always_ff @(posedge core_clk) begin
    if (reset || (tk.ce && tk.restart)) begin
      cyc_reg <= 32'h00000000;
    end else if (tk.ce) begin
      cyc_reg <= sec_end ? 32'h00000000 : cyc_reg + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Second counter within the minute
  always_ff @(posedge core_clk) begin
    if (reset || (tk.ce && tk.restart)) begin
      sec_reg <= 8'h00;
    end else if (tk.ce && sec_end) begin
      sec_reg <= (sec_reg == `CDSV_MIN_SECONDS - 8'h01) ? 8'h00 : sec_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unit tick, one cycle per selected time base
  always_ff @(posedge core_clk) begin
    if (reset || (tk.ce && tk.restart)) begin
      tk.unit_tick <= 1'b0;
    end else if (tk.ce) begin
      tk.unit_tick <= sec_end && (!tk.minute_mode || (sec_reg == `CDSV_MIN_SECONDS - 8'h01));
    end
  end

endmodule : cdsv_prescaler

// ---- cdsv_top.sv ----
`timescale 1ns/1ps
`include "cdsv_regs.svh"
module cdsv_top
  import cdsv_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `CDSV_SEC_CYCLES // Core cycles per second
) (
  input wire logic core_clk, // Core clock, 40 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic [15:0] io_addr, // I/O port address
  input wire logic io_wr, // I/O write strobe
  input wire logic io_rd, // I/O read strobe
  input wire logic [7:0] io_wdata, // I/O write data
  output logic [7:0] io_rdata_reg, // I/O read data, one cycle after strobe
  output logic sys_reset_reg // System reset request, active high
);

  ////////////////////////////////////////////////////////////////////////
  // Port decode helpers
  function automatic logic is_port(input logic [15:0] addr, input logic [15:0] port);
    is_port = (addr == port);
  endfunction : is_port

  cdsv_lock_type lock_reg; // Unlock sequence state
  cdsv_lock_type lock_next; // Next unlock state
  cdsv_byte_type index_reg; // Selected register index
  cdsv_byte_type ldn_reg; // Logical device select
  cdsv_byte_type activate_reg; // Device activation
  cdsv_byte_type control_reg; // Supervisor control
  cdsv_byte_type base_reg; // Time base select
  cdsv_byte_type timeout_reg; // Programmed time value
  cdsv_byte_type count_reg; // Live countdown value
  logic running_reg; // Countdown in progress
  logic [7:0] hold_reg; // Reset pulse cycles left
  logic idx_wr; // Write to index port
  logic dat_wr; // Write to data port while open
  logic dev_wr; // Data write to supervisor device
  logic armed; // Device active and armed
  logic reload; // Nonzero time value written
  logic unit_step; // Armed countdown sees a unit tick
  logic expire; // Last unit ends without a competing reload

  assign idx_wr = io_wr && is_port(io_addr, `CDSV_INDEX_PORT);
  assign dat_wr = io_wr && is_port(io_addr, `CDSV_DATA_PORT) && (lock_reg == CDSV_OPEN);
  assign dev_wr = dat_wr && (ldn_reg == `CDSV_SUPERVISOR_LDN);
  assign armed = activate_reg[`CDSV_ACTIVATE_BIT] && control_reg[`CDSV_CONTROL_ARM_BIT];
  assign reload = dev_wr && (index_reg == `CDSV_IDX_TIMEOUT) && (io_wdata != 8'h00);
  // A tick is only spent while the countdown runs and the device is armed,
  // so disarming pauses the count instead of losing it
  assign unit_step = running_reg && armed && tk.unit_tick;
  // A restart in the expiry cycle wins, so a late service write still saves the system
  assign expire = !reload && unit_step && (count_reg == 8'h01);

  cdsv_tick_if tk (); // Prescaler link
  assign tk.ce = clk_en;
  assign tk.restart = reload;
  assign tk.minute_mode = (base_reg == `CDSV_BASE_MINUTES);

  cdsv_prescaler #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_prescaler (
    .core_clk(core_clk),
    .reset(reset),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////
  // Unlock sequence: two unlock bytes in a row open, lock byte closes
  always_comb begin
    lock_next = lock_reg;
    if (idx_wr) begin
      case (lock_reg)
        CDSV_LOCKED: begin
          if (io_wdata == `CDSV_UNLOCK_BYTE) lock_next = CDSV_HALF;
        end
        CDSV_HALF: begin
          // Anything but a second unlock byte starts over
          lock_next = (io_wdata == `CDSV_UNLOCK_BYTE) ? CDSV_OPEN : CDSV_LOCKED;
        end
        CDSV_OPEN: begin
          if (io_wdata == `CDSV_LOCK_BYTE) lock_next = CDSV_LOCKED;
        end
        default: begin
          lock_next = CDSV_LOCKED;
        end
      endcase
    end else if (io_wr && lock_reg == CDSV_HALF) begin
      // A write to any other port breaks the unlock pair
      lock_next = CDSV_LOCKED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_reg <= CDSV_LOCKED;
    end else if (clk_en) begin
      lock_reg <= lock_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Index register, written through the index port while open
  // The lock byte closes the space and must not clobber the selected index
  always_ff @(posedge core_clk) begin
    if (reset) begin
      index_reg <= `CDSV_RST_BYTE;
    end else if (clk_en && idx_wr && lock_reg == CDSV_OPEN) begin
      if (io_wdata != `CDSV_LOCK_BYTE) index_reg <= io_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers written through the data port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ldn_reg <= `CDSV_RST_BYTE;
      activate_reg <= `CDSV_RST_BYTE;
      control_reg <= `CDSV_RST_BYTE;
      base_reg <= `CDSV_RST_TIME_BASE;
      timeout_reg <= `CDSV_RST_BYTE;
    end else if (clk_en) begin
      if (dat_wr && index_reg == `CDSV_IDX_LDN_SELECT) begin
        ldn_reg <= io_wdata;
      end else if (dev_wr && index_reg == `CDSV_IDX_ACTIVATE) begin
        activate_reg <= io_wdata;
      end else if (dev_wr && index_reg == `CDSV_IDX_CONTROL) begin
        control_reg <= io_wdata;
      end else if (dev_wr && index_reg == `CDSV_IDX_TIME_BASE) begin
        base_reg <= io_wdata;
      end else if (dev_wr && index_reg == `CDSV_IDX_TIMEOUT) begin
        timeout_reg <= io_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Countdown: load, decrement on each unit, stop at zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_reg <= `CDSV_RST_BYTE;
      running_reg <= 1'b0;
    end else if (clk_en) begin
      if (reload) begin
        // Reload wins over a tick in the same cycle
        count_reg <= io_wdata;
        running_reg <= 1'b1;
      end else if (dev_wr && index_reg == `CDSV_IDX_TIMEOUT) begin
        running_reg <= 1'b0;
      end else if (unit_step) begin
        count_reg <= count_reg - 8'h01;
        if (count_reg == 8'h01) running_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset request pulse, held for a fixed number of cycles
  // A fixed length gives the platform reset logic a clean, wide request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_reg <= 8'h00;
      sys_reset_reg <= 1'b0;
    end else if (clk_en) begin
      if (expire) begin
        hold_reg <= `CDSV_RST_HOLD_CYCLES - 8'h01;
        sys_reset_reg <= 1'b1;
      end else if (hold_reg != 8'h00) begin
        hold_reg <= hold_reg - 8'h01;
      end else begin
        sys_reset_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe
  // Reads have no side effects, so software may poll the live count freely
  always_ff @(posedge core_clk) begin
    if (reset) begin
      io_rdata_reg <= `CDSV_RST_IDLE_READ;
    end else if (clk_en && io_rd) begin
      if (lock_reg != CDSV_OPEN) begin
        io_rdata_reg <= `CDSV_RST_IDLE_READ; // Locked space floats high
      end else if (is_port(io_addr, `CDSV_INDEX_PORT)) begin
        io_rdata_reg <= index_reg;
      end else if (!is_port(io_addr, `CDSV_DATA_PORT)) begin
        io_rdata_reg <= `CDSV_RST_IDLE_READ;
      end else if (index_reg == `CDSV_IDX_LDN_SELECT) begin
        io_rdata_reg <= ldn_reg;
      end else if (ldn_reg != `CDSV_SUPERVISOR_LDN) begin
        io_rdata_reg <= `CDSV_RST_IDLE_READ;
      end else if (index_reg == `CDSV_IDX_ACTIVATE) begin
        io_rdata_reg <= activate_reg;
      end else if (index_reg == `CDSV_IDX_CONTROL) begin
        io_rdata_reg <= control_reg;
      end else if (index_reg == `CDSV_IDX_TIME_BASE) begin
        io_rdata_reg <= base_reg;
      end else if (index_reg == `CDSV_IDX_TIMEOUT) begin
        io_rdata_reg <= running_reg ? count_reg : timeout_reg; // Live count while running
      end else begin
        io_rdata_reg <= `CDSV_RST_IDLE_READ;
      end
    end
  end

endmodule : cdsv_top

// ---- cdsv_props.sv ----
`timescale 1ns/1ps
// Port-level checker for the supervisor top
module cdsv_props (
  input wire logic core_clk, // Clock
  input wire logic reset, // Reset
  input wire logic clk_en, // Enable
  input wire logic [15:0] io_addr, // Address
  input wire logic io_wr, // Write
  input wire logic io_rd, // Read
  input wire logic [7:0] io_wdata, // Write data
  input wire logic [7:0] io_rdata_reg, // Read data
  input wire logic sys_reset_reg // Reset request
);
  //////////////////////////////////////////
  logic [7:0] idx_reg; // Last index written
  logic half_reg; // First unlock byte seen
  logic opened_reg; // Space unlocked at least once; the lock byte does not clear it
  logic armed_reg; // Nonzero count loaded since last expiry or zero write
  wire dw = clk_en && io_wr && io_addr == 16'h002F; // Data write
  wire ld = dw && opened_reg && idx_reg == 8'hF6 && io_wdata != 8'h00; // Reload
  // Follow index, unlock and load state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {half_reg, opened_reg, armed_reg} <= 3'h0;
      idx_reg <= 8'h00;
    end else if (clk_en) begin
      if (io_wr) half_reg <= io_addr == 16'h002E && io_wdata == 8'h87 && !opened_reg;
      if (io_wr && io_addr == 16'h002E) idx_reg <= io_wdata;
      if (half_reg && io_wr && io_addr == 16'h002E && io_wdata == 8'h87) opened_reg <= 1'b1;
      if (ld) armed_reg <= 1'b1;
      else if ((dw && idx_reg == 8'hF6) || sys_reset_reg) armed_reg <= 1'b0;
    end
  end
  //////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_hold;
    $rose(sys_reset_reg) |-> sys_reset_reg[*8] ##1 sys_reset_reg[*8] ##1 !sys_reset_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("reset pulse length wrong");
  property p_rst;
    disable iff (1'b0) reset |=> io_rdata_reg == 8'hFF && !sys_reset_reg;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_stable;
    !io_rd |=> $stable(io_rdata_reg);
  endproperty
  a_stable: assert property (p_stable) else $error("read data moved");
  property p_locked;
    io_rd && !opened_reg |=> io_rdata_reg == 8'hFF;
  endproperty
  a_locked: assert property (p_locked) else $error("locked read not idle");
  property p_unmap;
    io_rd && io_addr[15:1] != 15'h0017 |=> io_rdata_reg == 8'hFF;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not idle");
  property p_reload;
    ld |=> (!$rose(sys_reset_reg))[*8];
  endproperty
  a_reload: assert property (p_reload) else $error("expiry too soon after load");
  property p_armed;
    $rose(sys_reset_reg) |-> armed_reg;
  endproperty
  a_armed: assert property (p_armed) else $error("expiry without load");
  property p_quiet;
    $fell(reset) |-> (!sys_reset_reg)[*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("request after reset");
  c_exp: cover property ($rose(sys_reset_reg));
  c_rd: cover property (io_rd && opened_reg);
  c_ld: cover property (ld);
endmodule : cdsv_props

bind cdsv_top cdsv_props u_props (.core_clk, .reset, .clk_en, .io_addr, .io_wr, .io_rd,
  .io_wdata, .io_rdata_reg, .sys_reset_reg);

// ---- testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench, one second is eight cycles
module testbench;
  logic core_clk = 1'b0; // Clock
  logic reset = 1'b1; // Reset
  logic clk_en, io_wr, io_rd, sys_reset_reg; // Controls
  logic [15:0] io_addr; // Address
  logic [7:0] io_wdata, io_rdata_reg, q; // Data
  int failures = 0; // Mismatches
  int num_checks = 0; // Comparisons
  int hi, first; // Pulse cycles, first pulse cycle
  always #12.5 core_clk = ~core_clk;
  cdsv_top #(.SEC_CYCLES(8)) DUT (.core_clk, .reset, .clk_en, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata_reg, .sys_reset_reg);
  //////////////////////////////////////////
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
  endtask : wr
  task cw(input logic [7:0] i, input logic [7:0] d);
    wr(16'h002E, i);
    wr(16'h002F, d);
  endtask : cw
  task rd(input logic [15:0] a);
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1 q = io_rdata_reg;
  endtask : rd
  // Count request cycles over n edges
  task cyc(input int n);
    hi = 0;
    first = 0;
    for (int k = 1; k <= n; k++) begin
      @(posedge core_clk);
      #1 if (sys_reset_reg === 1'b1) begin
        hi++;
        if (first == 0) first = k;
      end
    end
  endtask : cyc
  //////////////////////////////////////////
  task t_lock;
    rd(16'h002F);
    chk(q, 8'hFF);
    wr(16'h002E, 8'h87);
    wr(16'h002F, 8'h00);
    wr(16'h002E, 8'h87);
    rd(16'h002F);
    chk(q, 8'hFF);
    wr(16'h002E, 8'h87);
    rd(16'h0080);
    chk(q, 8'hFF);
  endtask : t_lock
  task t_cfg;
    cw(8'h07, 8'h07);
    cw(8'h30, 8'h01);
    cw(8'hF0, 8'h80);
    wr(16'h002E, 8'hF5);
    rd(16'h002F);
    chk(q, 8'h71);
    cw(8'hF6, 8'hFF);
    rd(16'h002F);
    chk(q, 8'hFF);
    cw(8'hF6, 8'h00);
  endtask : t_cfg
  // Other logical device is refused; the lock byte closes the space
  task t_refuse;
    cw(8'h07, 8'h08);
    wr(16'h002E, 8'hF5);
    rd(16'h002F);
    chk(q, 8'hFF);
    rd(16'h002E);
    chk(q, 8'hF5);
    cw(8'hF5, 8'h79);
    cw(8'h07, 8'h07);
    wr(16'h002E, 8'hF5);
    rd(16'h002F);
    chk(q, 8'h71);
    wr(16'h002E, 8'hAA);
    rd(16'h002E);
    chk(q, 8'hFF);
    wr(16'h002E, 8'h87);
    wr(16'h002E, 8'h87);
    rd(16'h002E);
    chk(q, 8'hF5);
  endtask : t_refuse
  task t_sec;
    cw(8'hF6, 8'h03);
    cyc(60);
    chk({7'h00, first >= 22 && first <= 28}, 8'h01);
    chk(8'(hi), 8'h10);
    cyc(60);
    chk(8'(hi), 8'h00);
  endtask : t_sec
  task t_reload;
    repeat (6) begin
      cw(8'hF6, 8'h02);
      cyc(8);
      chk(8'(hi), 8'h00);
    end
    @(posedge core_clk) clk_en <= 1'b0;
    cyc(40);
    chk(8'(hi), 8'h00);
    @(posedge core_clk) clk_en <= 1'b1;
    cw(8'hF6, 8'h00);
    cyc(60);
    chk(8'(hi), 8'h00);
  endtask : t_reload
  // Disarming pauses the count, re-arming resumes it
  task t_pause;
    cw(8'hF6, 8'h02);
    cw(8'hF0, 8'h00);
    cyc(40);
    chk(8'(hi), 8'h00);
    cw(8'hF0, 8'h80);
    cyc(30);
    chk(8'(first), 8'h09);
    chk(8'(hi), 8'h10);
  endtask : t_pause
  task t_min;
    cw(8'hF5, 8'h79);
    cw(8'hF6, 8'h01);
    cyc(470);
    chk(8'(hi), 8'h00);
    cyc(30);
    chk(8'(hi), 8'h10);
  endtask : t_min
  //////////////////////////////////////////
  task complete_run;
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    {clk_en, io_wr, io_rd, io_addr, io_wdata} = {1'b1, 26'h0};
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_lock;
    t_cfg;
    t_refuse;
    t_sec;
    t_reload;
    t_pause;
    t_min;
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    #(25 * 4000);
    failures++;
    complete_run;
  end
endmodule : testbench
